// file: hw/frame_ref_delay_mode_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - mode code: continuous, pulser, repeater, reserved
// - continuous mode outputs divider clock after delay
// - pulser emits burst per request pulse
// - repeater passes one pulse per request
// - inphase weights seven bits, reset all ones
// - quad weights bits 6-0, reset zero
// - out0 phase: iinv, qinv, i, q
// - other phases: iinv, qinv, q, i
// - logic output has own delay generator
// - out0 register bits 15-11 read zero
// - burst count 1..15, zero reserved
module frame_ref_delay_mode_regs #(
    parameter int REF_DIV = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiSdi,
    output logic spiSdo,
    input wire logic refRequestInput,
    input wire logic [3:0] burstPulseCount,
    input wire logic delayGenBypass,
    output logic refOut,
    output frame_ref_pkg::gen_mode_t genMode,
    output frame_ref_pkg::delay_cfg_t [frame_ref_pkg::NUM_OUTS-1:0] delayCfg
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sckSync_q, csSync_q, sdiSync_q, reqSync_q;
    always_ff @(posedge clk)
    begin
        sckSync_q <= {sckSync_q[1:0], spiSck};
        csSync_q <= {csSync_q[1:0], spiCsN};
        sdiSync_q <= {sdiSync_q[1:0], spiSdi};
        reqSync_q <= {reqSync_q[1:0], refRequestInput};
    end

    logic sckRise, sckFall, csActive, reqLevel, reqRise;
    assign sckRise = sckSync_q[1] & ~sckSync_q[2];
    assign sckFall = ~sckSync_q[1] & sckSync_q[2];
    assign csActive = ~csSync_q[1];
    assign reqLevel = reqSync_q[1];
    assign reqRise = reqSync_q[1] & ~reqSync_q[2];

    // ------------------------------------------------------------
    // serial configuration port
    // ------------------------------------------------------------
    logic [15:0] regs_q [frame_ref_pkg::NUM_REGS];
    logic [22:0] shiftIn_q;
    logic [4:0] bitCnt_q;
    logic [15:0] rdShift_q;
    logic [23:0] frameWord;
    logic [7:0] hdrWord;
    logic wrStrobe;
    logic [6:0] wrAddr;

    assign frameWord = {shiftIn_q, sdiSync_q[1]};
    assign hdrWord = frameWord[7:0];
    assign wrStrobe = csActive && sckRise && bitCnt_q == frame_ref_pkg::SPI_FRAME_LAST
        && !frameWord[23];
    assign wrAddr = frameWord[22:16];

    function automatic logic [15:0] readReg(input logic [6:0] addr,
                                            input logic [15:0] r0, r1, r2, r3, r4, r5);
        logic [15:0] data;
        unique case (addr)
            frame_ref_pkg::OUT0_DELAY_MODE_CFG_OFS: data = r0;
            frame_ref_pkg::OUT1_DELAY_OUT0_QUAD_CFG_OFS: data = r1;
            frame_ref_pkg::OUT2_DELAY_OUT1_QUAD_CFG_OFS: data = r2;
            frame_ref_pkg::OUT3_DELAY_OUT2_QUAD_CFG_OFS: data = r3;
            frame_ref_pkg::LOGIC_DELAY_OUT3_QUAD_CFG_OFS: data = r4;
            frame_ref_pkg::DELAY_SCALE_DIV_CFG_OFS: data = r5;
            default: data = 16'h0000;
        endcase
        return data;
    endfunction

    always_ff @(posedge clk)
    begin
        if (rst || !csActive)
        begin
            bitCnt_q <= 5'h00;
            shiftIn_q <= 23'h000000;
        end
        else if (sckRise)
        begin
            shiftIn_q <= frameWord[22:0];
            bitCnt_q <= (bitCnt_q == frame_ref_pkg::SPI_FRAME_LAST) ? 5'h00 : bitCnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdShift_q <= 16'h0000;
            spiSdo <= 1'b0;
        end
        else if (csActive && sckRise && bitCnt_q == frame_ref_pkg::SPI_HDR_LAST)
        begin
            rdShift_q <= hdrWord[7] ? readReg(hdrWord[6:0], regs_q[0], regs_q[1], regs_q[2],
                                              regs_q[3], regs_q[4], regs_q[5]) : 16'h0000;
        end
        else if (csActive && sckFall)
        begin
            spiSdo <= rdShift_q[15];
            rdShift_q <= {rdShift_q[14:0], 1'b0};
        end
    end

    // writes are stored as given except out0 bits 15-11, which are forced to zero; the weight sum is not policed
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            regs_q[0] <= frame_ref_pkg::OUT0_DELAY_MODE_CFG_RST;
            for (int k = 1; k < frame_ref_pkg::NUM_REGS - 1; k++)
                regs_q[k] <= frame_ref_pkg::WEIGHT_PHASE_CFG_RST;
            regs_q[5] <= frame_ref_pkg::DELAY_SCALE_DIV_CFG_RST;
        end
        else if (wrStrobe)
        begin
            unique case (wrAddr)
                frame_ref_pkg::OUT0_DELAY_MODE_CFG_OFS:
                    regs_q[0] <= frameWord[15:0] & frame_ref_pkg::OUT0_WRITE_MASK;
                frame_ref_pkg::OUT1_DELAY_OUT0_QUAD_CFG_OFS: regs_q[1] <= frameWord[15:0];
                frame_ref_pkg::OUT2_DELAY_OUT1_QUAD_CFG_OFS: regs_q[2] <= frameWord[15:0];
                frame_ref_pkg::OUT3_DELAY_OUT2_QUAD_CFG_OFS: regs_q[3] <= frameWord[15:0];
                frame_ref_pkg::LOGIC_DELAY_OUT3_QUAD_CFG_OFS: regs_q[4] <= frameWord[15:0];
                frame_ref_pkg::DELAY_SCALE_DIV_CFG_OFS: regs_q[5] <= frameWord[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // delay generator settings
    // ------------------------------------------------------------
    function automatic frame_ref_pkg::phase_sel_t decodePhase(input logic [1:0] code,
                                                             input logic isOut0);
        frame_ref_pkg::phase_sel_t sel;
        sel = '0;
        unique case (code)
            2'h0: sel.inphaseInv = 1'b1;
            2'h1: sel.quadInv = 1'b1;
            2'h2: if (isOut0) sel.inphase = 1'b1; else sel.quad = 1'b1;
            2'h3: if (isOut0) sel.quad = 1'b1; else sel.inphase = 1'b1;
        endcase
        return sel;
    endfunction

    for (genvar g = 0; g < frame_ref_pkg::NUM_OUTS; g++)
    begin : gen_delay
        always_ff @(posedge clk)
        begin
            if (g == 0)
            begin
                delayCfg[g].inphaseWeight <= regs_q[0][frame_ref_pkg::OUT0_INPHASE_LSB +: 7];
                delayCfg[g].phaseSel <= decodePhase(
                    regs_q[0][frame_ref_pkg::OUT0_PHASE_LSB +: 2], 1'b1);
            end
            else
            begin
                // g == 4 is the logic-clock generator
                delayCfg[g].inphaseWeight <= regs_q[g][frame_ref_pkg::INPHASE_LSB +: 7];
                delayCfg[g].phaseSel <= decodePhase(
                    regs_q[g][frame_ref_pkg::PHASE_LSB +: 2], 1'b0);
            end
            delayCfg[g].quadWeight <= regs_q[g+1][frame_ref_pkg::QUAD_LSB +: 7];
        end
    end

    always_ff @(posedge clk)
    begin
        genMode <= frame_ref_pkg::gen_mode_t'(regs_q[0][frame_ref_pkg::GEN_MODE_LSB +: 2]);
    end

    // ------------------------------------------------------------
    // reference divider and generation modes
    // ------------------------------------------------------------
    localparam int DIV_W = $clog2(REF_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(REF_DIV / 2);
    logic [DIV_W-1:0] divCnt_q;
    logic divClk_q;
    logic [3:0] burstLeft_q;
    logic refRaw_q, refDly_q;
    frame_ref_pkg::gen_mode_t mode;
    logic pulserStart;

    assign mode = frame_ref_pkg::gen_mode_t'(regs_q[0][frame_ref_pkg::GEN_MODE_LSB +: 2]);
    assign pulserStart = mode == frame_ref_pkg::MODE_PULSER && reqRise;

    // a pulser request restarts the divider so the burst begins on a full period
    always_ff @(posedge clk)
    begin
        if (rst || pulserStart || divCnt_q == DIV_LAST)
            divCnt_q <= '0;
        else
            divCnt_q <= divCnt_q + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            divClk_q <= 1'b0;
        else
            divClk_q <= pulserStart ? 1'b1 : (divCnt_q == DIV_LAST || divCnt_q < DIV_HALF - 1'b1);
    end

    // zero count is reserved and yields no burst
    always_ff @(posedge clk)
    begin
        if (rst || mode != frame_ref_pkg::MODE_PULSER)
            burstLeft_q <= 4'h0;
        else if (pulserStart)
            burstLeft_q <= burstPulseCount;
        else if (divCnt_q == DIV_LAST && burstLeft_q != 4'h0)
            burstLeft_q <= burstLeft_q - 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            refRaw_q <= 1'b0;
        else
        begin
            unique case (mode)
                frame_ref_pkg::MODE_CONTINUOUS: refRaw_q <= divClk_q;
                frame_ref_pkg::MODE_PULSER: refRaw_q <= divClk_q && burstLeft_q != 4'h0;
                frame_ref_pkg::MODE_REPEATER: refRaw_q <= reqLevel;
                frame_ref_pkg::MODE_RESERVED: refRaw_q <= 1'b0;
            endcase
        end
    end

    // the retimer stage is skipped when the delay generators are bypassed
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            refDly_q <= 1'b0;
            refOut <= 1'b0;
        end
        else
        begin
            refDly_q <= refRaw_q;
            refOut <= delayGenBypass ? refRaw_q : refDly_q;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence modeHeld(frame_ref_pkg::gen_mode_t m);
        (mode == m && delayGenBypass)[*3];
    endsequence
    out0_high_zero_a: assert property (regs_q[0][15:11] == 5'h00)
        else $error("out0 register upper bits not zero");
    reserved_mode_quiet_a: assert property (
        modeHeld(frame_ref_pkg::MODE_RESERVED) |-> !refOut)
        else $error("output active in reserved mode");
    continuous_follow_a: assert property (
        modeHeld(frame_ref_pkg::MODE_CONTINUOUS) |-> refOut == $past(divClk_q, 2))
        else $error("continuous output does not follow divider");
    burst_load_a: assert property (pulserStart |=> burstLeft_q == $past(burstPulseCount))
        else $error("burst count not loaded on request");
    repeater_pass_a: assert property (
        modeHeld(frame_ref_pkg::MODE_REPEATER) |-> refOut == $past(reqLevel, 2))
        else $error("repeater output does not follow request");
    out0_phase_map_a: assert property (
        regs_q[0][3:2] == 2'h3 ##1 regs_q[0][3:2] == 2'h3 |-> delayCfg[0].phaseSel.quad)
        else $error("out0 phase code 3 not quadrature");
    out1_phase_map_a: assert property (
        regs_q[1][8:7] == 2'h3 ##1 regs_q[1][8:7] == 2'h3 |-> delayCfg[1].phaseSel.inphase)
        else $error("out1 phase code 3 not in-phase");
    logic_reset_a: assert property (disable iff (1'b0)
        $fell(rst) |-> ##1 delayCfg[4].inphaseWeight == 7'h7F && delayCfg[4].quadWeight == 7'h00)
        else $error("logic generator weights not at reset value");
    weight_store_a: assert property (
        wrStrobe && wrAddr == frame_ref_pkg::OUT1_DELAY_OUT0_QUAD_CFG_OFS
        |=> regs_q[1] == $past(frameWord[15:0]))
        else $error("write not stored unchanged");
endmodule
`default_nettype wire

// file: hw/frame_ref_pkg.sv
package frame_ref_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [6:0] OUT0_DELAY_MODE_CFG_OFS = 7'h11;
    localparam logic [6:0] OUT1_DELAY_OUT0_QUAD_CFG_OFS = 7'h12;
    localparam logic [6:0] OUT2_DELAY_OUT1_QUAD_CFG_OFS = 7'h13;
    localparam logic [6:0] OUT3_DELAY_OUT2_QUAD_CFG_OFS = 7'h14;
    localparam logic [6:0] LOGIC_DELAY_OUT3_QUAD_CFG_OFS = 7'h15;
    localparam logic [6:0] DELAY_SCALE_DIV_CFG_OFS = 7'h16;
    localparam int NUM_REGS = 6;
    localparam int NUM_OUTS = 5;

    localparam logic [15:0] OUT0_DELAY_MODE_CFG_RST = 16'h07F0;
    localparam logic [15:0] WEIGHT_PHASE_CFG_RST = 16'hFE00;
    localparam logic [15:0] DELAY_SCALE_DIV_CFG_RST = 16'h0800;
    // bits 15-11 of the out0 register are read-only zero
    localparam logic [15:0] OUT0_WRITE_MASK = 16'h07FF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GEN_MODE_LSB = 0;
    localparam int OUT0_PHASE_LSB = 2;
    localparam int OUT0_INPHASE_LSB = 4;
    localparam int QUAD_LSB = 0;
    localparam int PHASE_LSB = 7;
    localparam int INPHASE_LSB = 9;
    localparam int WEIGHT_W = 7;

    // ------------------------------------------------------------
    // serial port framing: rw bit, 7-bit address, 16-bit data
    // ------------------------------------------------------------
    localparam logic [4:0] SPI_HDR_LAST = 5'd7;
    localparam logic [4:0] SPI_FRAME_LAST = 5'd23;

    typedef enum logic [1:0] {
        MODE_CONTINUOUS = 2'h0,
        MODE_PULSER = 2'h1,
        MODE_REPEATER = 2'h2,
        MODE_RESERVED = 2'h3
    } gen_mode_t;

    // one-hot retimer clock choice
    typedef struct packed {
        logic inphaseInv;
        logic quadInv;
        logic inphase;
        logic quad;
    } phase_sel_t;

    typedef struct packed {
        logic [WEIGHT_W-1:0] inphaseWeight;
        logic [WEIGHT_W-1:0] quadWeight;
        phase_sel_t phaseSel;
    } delay_cfg_t;

endpackage

// file: testbench/frame_ref_delay_mode_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module frame_ref_delay_mode_regs_tb_top;
    logic clk, rst, spiSck, spiCsN, spiSdi, spiSdo, refRequestInput, delayGenBypass, refOut;
    logic clear;
    logic [3:0] burstPulseCount;
    logic [7:0] pulses;
    frame_ref_pkg::gen_mode_t genMode;
    frame_ref_pkg::delay_cfg_t [frame_ref_pkg::NUM_OUTS-1:0] delayCfg;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    frame_ref_delay_mode_regs #(.REF_DIV(4)) i_frame_ref_delay_mode_regs (
        .clk(clk), .rst(rst), .spiSck(spiSck), .spiCsN(spiCsN), .spiSdi(spiSdi),
        .spiSdo(spiSdo), .refRequestInput(refRequestInput),
        .burstPulseCount(burstPulseCount), .delayGenBypass(delayGenBypass),
        .refOut(refOut), .genMode(genMode), .delayCfg(delayCfg));
    frame_ref_sink i_frame_ref_sink (.clk(clk), .clear(clear), .refIn(refOut), .pulses(pulses));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard: a full run needs just under half of this
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one frame: rw, 7-bit address, 16-bit data, msb first; sck half period 8 clk
    task automatic spi(input logic rw, input logic [6:0] a, input logic [15:0] wd,
                       output logic [15:0] rd);
        logic [23:0] frame;
        frame = {rw, a, wd};
        rd = 16'h0000;
        @(posedge clk) spiCsN <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge clk);
            spiSck <= 1'b0;
            spiSdi <= frame[i];
            repeat (7) @(posedge clk);
            @(negedge clk);
            if (i < 16)
                rd[i] = spiSdo;
            @(posedge clk) spiSck <= 1'b1;
            repeat (7) @(posedge clk);
        end
        @(posedge clk) spiSck <= 1'b0;
        repeat (8) @(posedge clk);
        spiCsN <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] unused;
        spi(1'b0, a, d, unused);
    endtask

    task automatic rdChk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] v;
        spi(1'b1, a, 16'h0000, v);
        chk($sformatf("register %h", a), v, exp);
    endtask

    // request pulse, then count output pulses over a fixed window
    task automatic burst(input int window);
        @(posedge clk) clear <= 1'b1;
        @(posedge clk) clear <= 1'b0;
        refRequestInput <= 1'b1;
        repeat (3) @(posedge clk);
        refRequestInput <= 1'b0;
        repeat (window) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testReset();
        rdChk(7'h11, 16'h07F0);
        rdChk(7'h12, 16'hFE00);
        rdChk(7'h15, 16'hFE00);
        rdChk(7'h16, 16'h0800);
        chk("mode", 16'(genMode), 16'h0000);
        chk("logic inphase", 16'(delayCfg[4].inphaseWeight), 16'h007F);
        chk("out0 quad", 16'(delayCfg[0].quadWeight), 16'h0000);
        chk("out0 phase", 16'(delayCfg[0].phaseSel), 16'h0008);
        $display("test reset done");
    endtask

    task automatic testContinuous();
        for (int b = 0; b < 2; b++)
        begin
            delayGenBypass <= b[0];
            burst(40);
            clear <= 1'b1;
            @(posedge clk) clear <= 1'b0;
            repeat (40) @(posedge clk);
            // let the count of the last edge settle before reading it
            @(negedge clk);
            chk("continuous pulses", 16'(pulses), 16'h000A);
        end
        $display("test continuous done");
    endtask

    task automatic testReadOnly();
        wr(7'h11, 16'hFFFF);
        rdChk(7'h11, 16'h07FF);
        chk("mode", 16'(genMode), 16'h0003);
        burst(40);
        chk("reserved mode pulses", 16'(pulses), 16'h0000);
        $display("test read-only done");
    endtask

    task automatic testPhase();
        logic [3:0] out0Map [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
        logic [3:0] otherMap [4] = '{4'h8, 4'h4, 4'h1, 4'h2};
        for (int c = 0; c < 4; c++)
        begin
            wr(7'h11, {5'h00, 7'h55, c[1:0], 2'h0});
            wr(7'h12, {7'h55, c[1:0], 7'h2A});
            wr(7'h13, {7'h55, c[1:0], 7'h2A});
            chk("out0 phase", 16'(delayCfg[0].phaseSel), 16'(out0Map[c]));
            chk("out1 phase", 16'(delayCfg[1].phaseSel), 16'(otherMap[c]));
            chk("out0 quad", 16'(delayCfg[0].quadWeight), 16'h002A);
            chk("out2 phase", 16'(delayCfg[2].phaseSel), 16'(otherMap[c]));
            chk("out2 inphase", 16'(delayCfg[2].inphaseWeight), 16'h0055);
            chk("out1 quad", 16'(delayCfg[1].quadWeight), 16'h002A);
        end
        $display("test phase done");
    endtask

    task automatic testUnmapped();
        wr(7'h20, 16'h1234);
        rdChk(7'h20, 16'h0000);
        rdChk(7'h13, {7'h55, 2'h3, 7'h2A});
        $display("test unmapped done");
    endtask

    task automatic testRepeater();
        wr(7'h11, 16'h07F2);
        for (int b = 0; b < 2; b++)
        begin
            delayGenBypass <= b[0];
            burst(20);
            chk("repeater pulses", 16'(pulses), 16'h0001);
        end
        $display("test repeater done");
    endtask

    task automatic testPulser();
        logic [3:0] counts [4] = '{4'h1, 4'h3, 4'hF, 4'h0};
        wr(7'h11, 16'h07F1);
        for (int k = 0; k < 4; k++)
        begin
            burstPulseCount <= counts[k];
            burst(4 * 15 + 20);
            chk("burst pulses", 16'(pulses), 16'(counts[k]));
        end
        $display("test pulser done");
    endtask

    initial
    begin
        rst = 1'b1;
        spiSck = 1'b0;
        spiCsN = 1'b1;
        spiSdi = 1'b0;
        refRequestInput = 1'b0;
        burstPulseCount = 4'h1;
        delayGenBypass = 1'b0;
        clear = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        testReset();
        testContinuous();
        testReadOnly();
        testPhase();
        testUnmapped();
        testRepeater();
        testPulser();
        results();
    end
endmodule

`default_nettype wire

// file: testbench/frame_ref_sink.sv
`timescale 1ns/1ps
`default_nettype none

// downstream receiver: counts rising edges of the frame reference line
module frame_ref_sink (
    input wire logic clk,
    input wire logic clear,
    input wire logic refIn,
    output logic [7:0] pulses
);
    logic prevRef_q;

    always_ff @(posedge clk)
    begin
        prevRef_q <= refIn;
        if (clear)
            pulses <= 8'h00;
        else if (refIn && !prevRef_q)
            pulses <= pulses + 8'h01;
    end
endmodule

`default_nettype wire
